/* rtl/ppc_pkg.sv */
// pulse period capture timer: shared constants, register map and bus carriers
// assumes a 50 MHz aclk and an AXI4-Lite master on the register side
package ppc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register indexes; byte address is four times the index
  localparam int          ADDR_W    = 20;
  localparam int          IDX_W     = 18;
  localparam logic [17:0] IDX_START = 18'h0F030;
  localparam logic [17:0] IDX_CTRL  = 18'h0F040;
  localparam logic [17:0] IDX_MODE  = 18'h0F041;
  localparam logic [17:0] IDX_IO    = 18'h0F042;
  localparam logic [17:0] IDX_IEN   = 18'h0F044;
  localparam logic [17:0] IDX_STAT  = 18'h0F045;
  localparam logic [17:0] IDX_CNT   = 18'h0F046;
  localparam logic [17:0] IDX_CAPT  = 18'h0F048;

  //////////////////////////////////////////////////////////////////////////////
  // field positions and codes
  localparam int        RUN_BIT       = 1;
  localparam int        PSC_LSB       = 0;
  localparam int        EDGE_LSB      = 3;
  localparam int        CCLR_LSB      = 5;
  localparam int        MODE_LSB      = 0;
  localparam int        IOA_LSB       = 0;
  localparam int        OVF_BIT       = 4;
  localparam int        CAPF_BIT      = 0;
  localparam int        OVF_IEN_BIT   = 4;
  localparam int        CAP_IEN_BIT   = 0;
  localparam logic [2:0] PSC_DIV256    = 3'h6;
  localparam logic [1:0] EDGE_RISE     = 2'h0;
  localparam logic [1:0] CCLR_CAPT_A   = 2'h1;
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [3:0] IOA_CAPT_RISE = 4'h8;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // reset values and counter maximum
  localparam logic [7:0]  RST_REG8  = 8'h00;
  localparam logic [15:0] RST_CNT   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;

  //////////////////////////////////////////////////////////////////////////////
  // timing: counter input clock is aclk divided by 256
  localparam int CLK_PERIOD_NS = 20;
  localparam int DIV_RATIO     = 256;
  localparam int TICK_NS       = DIV_RATIO * CLK_PERIOD_NS;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    REG_NONE, REG_START, REG_CTRL, REG_MODE, REG_IO,
    REG_IEN, REG_STAT, REG_CNT, REG_CAPT
  } ppc_reg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } ppc_wr_t;

  function automatic ppc_reg_t ppc_decode(input logic [ADDR_W-1:0] a);
    ppc_reg_t r;
    r = REG_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[ADDR_W-1:2])
        IDX_START: r = REG_START;
        IDX_CTRL:  r = REG_CTRL;
        IDX_MODE:  r = REG_MODE;
        IDX_IO:    r = REG_IO;
        IDX_IEN:   r = REG_IEN;
        IDX_STAT:  r = REG_STAT;
        IDX_CNT:   r = REG_CNT;
        IDX_CAPT:  r = REG_CAPT;
        default:   r = REG_NONE;
      endcase
    end
    return r;
  endfunction : ppc_decode

endpackage : ppc_pkg

/* rtl/ppc_prescaler.sv */
// pulse period capture timer: divide-by-256 count enable
// assumes en comes from logic on aclk
`timescale 1ns/1ps
`default_nettype none
module ppc_prescaler
  import ppc_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic en,
  output logic      tick
);

  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic       next_tick;

  always_comb begin
    next_div_cnt = 8'h00;
    next_tick    = 1'b0;
    if (en) begin
      next_div_cnt = div_cnt + 8'h01;
      next_tick    = (div_cnt == 8'(TICK_CYCLES - 1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 8'h00;
      tick    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

endmodule : ppc_prescaler
`default_nettype wire

/* rtl/ppc_axil_slave.sv */
// pulse period capture timer: AXI4-Lite slave front end
// assumes rd_data/rd_err answer combinationally to rd_addr, wr_err to wr_req
`timescale 1ns/1ps
`default_nettype none
module ppc_axil_slave
  import ppc_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // register file side
  output ppc_wr_t                wr_req,
  output logic                   wr_en,
  input  wire logic              wr_err,
  output logic [ADDR_W-1:0]      rd_addr,
  output logic                   rd_en,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);

  logic    aw_full, w_full, next_aw_full, next_w_full;
  logic    next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  ppc_wr_t next_wr_req;

  assign awready = !aw_full && !bvalid;
  assign wready  = !w_full && !bvalid;
  assign arready = !rvalid;
  assign wr_en   = aw_full && w_full && !bvalid;
  assign rd_addr = araddr;
  assign rd_en   = arvalid && arready;

  always_comb begin
    next_wr_req = wr_req;
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    next_rvalid  = rvalid && !rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready) begin
      next_aw_full     = 1'b1;
      next_wr_req.addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_full      = 1'b1;
      next_wr_req.data = wdata;
      next_wr_req.strb = wstrb;
    end
    if (wr_en) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (rd_en) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_data;
      next_rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_req  <= '0;
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      wr_req  <= next_wr_req;
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

endmodule : ppc_axil_slave
`default_nettype wire

/* rtl/ppc_timer.sv */
// pulse period capture timer: one 16-bit channel measuring pulse periods
// assumes an AXI4-Lite master, 50 MHz aclk and an asynchronous capture pin
//
// Functional notes
// RULE1 - prescale field 110 advances the counter once per 256 system clocks
// RULE2 - clock-edge field 00 counts on the rising edge of the input clock
// RULE3 - clear-source field 01 clears the counter on each channel A capture
// RULE4 - mode field 00 selects normal operation
// RULE5 - I/O field 1000 makes channel A capture on rising pin edges
// RULE6 - counter runs only while the run bit is set, else holds
// RULE7 - the 16-bit counter is readable and writable by software
// RULE8 - each capture copies the counter into the 16-bit capture register
// RULE9 - separate enables gate overflow and capture flags onto requests
// RULE10 - status holds overflow and capture flags that source the requests
// RULE11 - period equals captured count times the counter input clock period
// RULE12 - overflow flag sets on FFFF to 0000, cleared by read-1 then write-0
// RULE13 - capture flag sets on capture, cleared by read-1 then write-0 only
// RULE14 - counter resets to 0000 and is accessed only as a whole 16-bit word
// RULE15 - capture pin is synchronised before edge detection, one capture per edge
// RULE16 - capture takes the pre-clear value when it meets an increment
`timescale 1ns/1ps
`default_nettype none
module ppc_timer
  import ppc_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // external pulse
  input  wire logic              capture_input_pin,
  // interrupt requests
  output logic                   overflow_irq_request,
  output logic                   capture_a_irq_request
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0]  timer_start_control;
  logic [7:0]  channel_clock_clear_control;
  logic [7:0]  channel_operating_mode;
  logic [7:0]  channel_io_function_control;
  logic [7:0]  channel_interrupt_enables;
  logic [15:0] channel_counter;
  logic [15:0] channel_a_capture_reg;
  logic        overflow_flag;
  logic        capture_a_flag;
  logic        ovf_read_armed;
  logic        capf_read_armed;

  logic [7:0]  next_start, next_ctrl, next_mode, next_io, next_ien;
  logic [15:0] next_counter;
  logic [15:0] next_capture;
  logic        next_overflow_flag, next_capture_a_flag;
  logic        next_ovf_armed, next_capf_armed;
  logic        next_ovf_irq, next_cap_irq;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end
  ppc_wr_t           wr_req;
  logic              wr_en;
  logic              wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic              rd_en;
  logic [31:0]       rd_data;
  logic              rd_err;
  ppc_reg_t          wr_sel;
  ppc_reg_t          rd_sel;

  ppc_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_req  (wr_req),
    .wr_en   (wr_en),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  assign wr_sel = ppc_decode(wr_req.addr);
  assign rd_sel = ppc_decode(rd_addr);
  assign wr_err = (wr_sel == REG_NONE);
  assign rd_err = (rd_sel == REG_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // capture pin synchroniser and rising edge detect
  logic pin_meta, pin_sync, pin_prev;
  logic pin_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= capture_input_pin; // [RULE15]
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync && !pin_prev; // [RULE15]

  ////////////////////////////////////////////////////////////////////////////
  // field decode and count enable
  logic       run;
  logic [2:0] psc_sel;
  logic [1:0] edge_sel;
  logic [1:0] clear_sel;
  logic [1:0] op_mode;
  logic [3:0] chan_a_func;
  logic       count_en;
  logic       tick;
  logic       capture;
  logic       capture_clear;
  logic       count_step;
  logic       wrap;

  assign run         = timer_start_control[RUN_BIT];
  assign psc_sel     = channel_clock_clear_control[PSC_LSB +: 3];
  assign edge_sel    = channel_clock_clear_control[EDGE_LSB +: 2];
  assign clear_sel   = channel_clock_clear_control[CCLR_LSB +: 2];
  assign op_mode     = channel_operating_mode[MODE_LSB +: 2];
  assign chan_a_func = channel_io_function_control[IOA_LSB +: 4];

  // only the documented prescale, edge and mode setup counts; other selections of these fields hold the counter
  assign count_en = run                       // [RULE6]
                 && (psc_sel == PSC_DIV256)   // [RULE1]
                 && (edge_sel == EDGE_RISE)   // [RULE2]
                 && (op_mode == MODE_NORMAL); // [RULE4]

  ppc_prescaler u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (count_en),
    .tick    (tick)
  );

  assign capture       = pin_rise && (chan_a_func == IOA_CAPT_RISE); // [RULE5]
  assign capture_clear = capture && (clear_sel == CCLR_CAPT_A);     // [RULE3]
  assign count_step    = tick && count_en;                          // [RULE1]
  assign wrap          = count_step && !capture_clear
                      && (channel_counter == CNT_MAX);              // [RULE12]

  ////////////////////////////////////////////////////////////////////////////
  // register write, counter and flag next state
  logic wr_lo, wr_word, wr_stat;

  assign wr_lo   = wr_en && wr_req.strb[0];
  assign wr_word = wr_en && (wr_req.strb[1:0] == 2'h3); // [RULE14]
  assign wr_stat = wr_lo && (wr_sel == REG_STAT);

  always_comb begin
    next_start          = timer_start_control;
    next_ctrl           = channel_clock_clear_control;
    next_mode           = channel_operating_mode;
    next_io             = channel_io_function_control;
    next_ien            = channel_interrupt_enables;
    next_counter        = channel_counter;
    next_capture        = channel_a_capture_reg;
    next_overflow_flag  = overflow_flag;
    next_capture_a_flag = capture_a_flag;
    next_ovf_armed      = ovf_read_armed;
    next_capf_armed     = capf_read_armed;
    if (wr_lo) begin
      case (wr_sel)
        REG_START: next_start = wr_req.data[7:0];
        REG_CTRL:  next_ctrl  = wr_req.data[7:0];
        REG_MODE:  next_mode  = wr_req.data[7:0];
        REG_IO:    next_io    = wr_req.data[7:0];
        REG_IEN:   next_ien   = wr_req.data[7:0];
        default:   next_start = timer_start_control;
      endcase
    end
    // a flag seen as 1 by a read arms its write-0 clear
    if (rd_en && rd_sel == REG_STAT) begin
      next_ovf_armed  = ovf_read_armed || overflow_flag;   // [RULE12]
      next_capf_armed = capf_read_armed || capture_a_flag; // [RULE13]
    end
    if (wr_stat && !wr_req.data[OVF_BIT] && ovf_read_armed) begin
      next_overflow_flag = 1'b0; // [RULE12]
      next_ovf_armed     = 1'b0;
    end
    if (wr_stat && !wr_req.data[CAPF_BIT] && capf_read_armed) begin
      next_capture_a_flag = 1'b0; // [RULE13]
      next_capf_armed     = 1'b0;
    end
    // hardware events win over a clear in the same cycle
    if (wrap) begin
      next_overflow_flag = 1'b1; // [RULE12]
    end
    if (capture) begin
      next_capture_a_flag = 1'b1; // [RULE13]
    end
    // counter: capture clear beats a software write, which beats a step
    if (capture_clear) begin
      next_counter = RST_CNT; // [RULE3] [RULE16]
    end else if (wr_word && wr_sel == REG_CNT) begin
      next_counter = wr_req.data[15:0]; // [RULE7] [RULE14]
    end else if (count_step) begin
      next_counter = channel_counter + 16'h0001; // [RULE1] [RULE11]
    end
    if (capture) begin
      next_capture = channel_counter; // [RULE8] [RULE16]
    end else if (wr_word && wr_sel == REG_CAPT) begin
      next_capture = wr_req.data[15:0]; // [RULE8]
    end
    next_ovf_irq = overflow_flag && channel_interrupt_enables[OVF_IEN_BIT];  // [RULE9] [RULE10]
    next_cap_irq = capture_a_flag && channel_interrupt_enables[CAP_IEN_BIT]; // [RULE9] [RULE10]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_start_control         <= RST_REG8;
      channel_clock_clear_control <= RST_REG8;
      channel_operating_mode      <= RST_REG8;
      channel_io_function_control <= RST_REG8;
      channel_interrupt_enables   <= RST_REG8;
      channel_counter             <= RST_CNT; // [RULE14]
      channel_a_capture_reg       <= RST_CNT;
      overflow_flag               <= 1'b0;
      capture_a_flag              <= 1'b0;
      ovf_read_armed              <= 1'b0;
      capf_read_armed             <= 1'b0;
      overflow_irq_request        <= 1'b0;
      capture_a_irq_request       <= 1'b0;
    end else begin
      timer_start_control         <= next_start;
      channel_clock_clear_control <= next_ctrl;
      channel_operating_mode      <= next_mode;
      channel_io_function_control <= next_io;
      channel_interrupt_enables   <= next_ien;
      channel_counter             <= next_counter;
      channel_a_capture_reg       <= next_capture;
      overflow_flag               <= next_overflow_flag;
      capture_a_flag              <= next_capture_a_flag;
      ovf_read_armed              <= next_ovf_armed;
      capf_read_armed             <= next_capf_armed;
      overflow_irq_request        <= next_ovf_irq;
      capture_a_irq_request       <= next_cap_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer
  logic [7:0] status_byte;

  always_comb begin
    status_byte           = 8'h00;
    status_byte[OVF_BIT]  = overflow_flag;
    status_byte[CAPF_BIT] = capture_a_flag;
    rd_data               = 32'h00000000;
    case (rd_sel)
      REG_START: rd_data[7:0]  = timer_start_control;
      REG_CTRL:  rd_data[7:0]  = channel_clock_clear_control;
      REG_MODE:  rd_data[7:0]  = channel_operating_mode;
      REG_IO:    rd_data[7:0]  = channel_io_function_control;
      REG_IEN:   rd_data[7:0]  = channel_interrupt_enables;
      REG_STAT:  rd_data[7:0]  = status_byte;
      REG_CNT:   rd_data[15:0] = channel_counter;       // [RULE7]
      REG_CAPT:  rd_data[15:0] = channel_a_capture_reg; // [RULE8]
      default:   rd_data       = 32'h00000000;
    endcase
  end

endmodule : ppc_timer
`default_nettype wire

/* bench/ppc_pulse_src.sv */
// external pulse source on the capture pin
// assumes period in aclk cycles, 6 or more
`timescale 1ns/1ps
`default_nettype none
module ppc_pulse_src (
  // clock
  input  wire logic        aclk,
  // control
  input  wire logic        en,
  input  wire logic [15:0] period,
  // pin
  output logic             pin
);
  logic [15:0] cnt = 16'h0000;
  initial pin = 1'b0;
  // edges land 3 ns past the clock, unrelated to the sampling edge
  always @(posedge aclk) begin
    cnt <= (!en || cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
    pin <= #3 en && (cnt < period / 2);
  end
endmodule : ppc_pulse_src
`default_nettype wire

/* bench/ppc_timer_assertions.sv */
// port checker for the pulse period timer
// assumes it is bound into ppc_timer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ppc_timer_assertions
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // requests
  input wire logic        overflow_irq_request,
  input wire logic        capture_a_irq_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  a_aw_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
  a_ar_refuse:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken twice");
  a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits set");
  a_irq_reset:
    assert property (disable iff (1'b0) !aresetn |=> !overflow_irq_request
      && !capture_a_irq_request) else $error("request survives reset");
  a_cap_clear:
    assert property ($fell(capture_a_irq_request) |-> s_axi_bvalid
      || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("capture flag lost");
  a_ovf_clear:
    assert property ($fell(overflow_irq_request) |-> s_axi_bvalid
      || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("overflow flag lost");
endmodule : ppc_timer_assertions
bind ppc_timer ppc_timer_assertions u_ppc_timer_assertions (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .overflow_irq_request(overflow_irq_request), .capture_a_irq_request(capture_a_irq_request)
);
`default_nettype wire

/* bench/ppc_timer_tb_top.sv */
// testbench for the pulse period timer: bus master, pulse source, scoreboard
// assumes ppc_timer, ppc_pulse_src and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, c, e, s) begin check_count++; if ((c) !== 1'b1) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module ppc_timer_tb_top
  import ppc_pkg::*;
;
  typedef struct { string n; logic [33:0] e; logic [33:0] t; } ppc_note_t;
  logic              aclk, awready, wready, bvalid, arready, rvalid, pin, ovf_irq, cap_irq;
  logic              aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic              rready = 0, pin_en = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata, v;
  logic [3:0]        wstrb = '0;
  logic [1:0]        bresp, rresp;
  int                n_mismatch, check_count;
  ppc_note_t         rq[$], bq[$];
  logic [17:0]       idx[8] = '{IDX_START, IDX_CTRL, IDX_MODE, IDX_IO, IDX_IEN,
                                IDX_STAT, IDX_CNT, IDX_CAPT};
  logic [7:0]        msk[5] = '{8'h02, 8'h7F, 8'h03, 8'h0F, 8'h11};

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  ppc_timer u_ppc_timer (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_input_pin(pin),
    .overflow_irq_request(ovf_irq), .capture_a_irq_request(cap_irq)
  );
  ppc_pulse_src u_ppc_pulse_src (.aclk(aclk), .en(pin_en), .period(16'h0380), .pin(pin));

  ////////////////////////////////////////
  // scoreboard: oldest note against each answer
  task automatic chk(input ppc_note_t x, input logic [33:0] s);
    `CHK(x.n, (s - x.e) <= x.t, x.e, s)
  endtask : chk

  always @(posedge aclk) begin
    if (rvalid && rready) chk(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk(bq.pop_front(), {32'h0, bresp});
  end

  ////////////////////////////////////////
  task automatic wr(input logic [17:0] i, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic a, w;
    bq.push_back('{"bresp", {32'h0, r}, 34'h0});
    a = 1'b1;
    w = 1'b1;
    awaddr <= {i, 2'h0};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (a || w) begin
      @(posedge aclk);
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    @(posedge aclk iff bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [17:0] i, input logic [33:0] e, input logic [33:0] t,
                    input string n);
    rq.push_back('{n, e, t});
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk iff arready);
    arvalid <= 1'b0;
    @(posedge aclk iff rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    finish_test();
  end

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hF19BF9BD));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (idx[k]) rd(idx[k], 34'h0, 34'h0, "reset value");
    rd(18'h0F047, {RESP_SLVERR, 32'h0}, 34'h0, "unmapped");
    wr(18'h0F047, 32'hFF, 4'hF, RESP_SLVERR);
    for (int k = 0; k < 5; k++) begin
      v = $urandom() & {24'h0, msk[k]};
      wr(idx[k], v, 4'h1, RESP_OKAY);
      rd(idx[k], {2'h0, v}, 34'h0, "control");
    end
    wr(IDX_START, 32'h0, 4'h1, RESP_OKAY);
    wr(IDX_CTRL, 32'h26, 4'h1, RESP_OKAY);
    wr(IDX_MODE, 32'h0, 4'h1, RESP_OKAY);
    wr(IDX_IO, 32'h8, 4'h1, RESP_OKAY);
    wr(IDX_IEN, 32'h11, 4'h1, RESP_OKAY);
    v = $urandom();
    wr(IDX_CNT, v, 4'hF, RESP_OKAY);
    wr(IDX_CNT, ~v, 4'h1, RESP_OKAY);
    repeat (600) @(posedge aclk);
    rd(IDX_CNT, {18'h0, v[15:0]}, 34'h0, "held count");
    // two ticks from FFFE wrap to 0000
    wr(IDX_CNT, 32'hFFFE, 4'h3, RESP_OKAY);
    wr(IDX_START, 32'h2, 4'h1, RESP_OKAY);
    repeat (640) @(posedge aclk);
    rd(IDX_CNT, 34'h0, 34'h0, "wrapped");
    `CHK("ovf irq", ovf_irq, 1'b1, ovf_irq)
    // a set flag with its enable off must not request
    wr(IDX_IEN, 32'h01, 4'h1, RESP_OKAY);
    `CHK("ovf masked", ~ovf_irq, 1'b0, ovf_irq)
    wr(IDX_IEN, 32'h11, 4'h1, RESP_OKAY);
    `CHK("ovf unmasked", ovf_irq, 1'b1, ovf_irq)
    rd(IDX_STAT, 34'h10, 34'h0, "status");
    wr(IDX_STAT, 32'h0, 4'h1, RESP_OKAY);
    `CHK("ovf clear", ~ovf_irq, 1'b0, ovf_irq)
    // 896-cycle period holds 3.5 ticks
    pin_en <= 1'b1;
    @(posedge aclk iff cap_irq);
    wr(IDX_STAT, 32'h11, 4'h1, RESP_OKAY);
    wr(IDX_STAT, 32'h0, 4'h1, RESP_OKAY);
    `CHK("cap kept", cap_irq, 1'b1, cap_irq)
    rd(IDX_STAT, 34'h1, 34'h0, "status");
    wr(IDX_STAT, 32'h0, 4'h1, RESP_OKAY);
    `CHK("cap clear", ~cap_irq, 1'b0, cap_irq)
    @(posedge aclk iff cap_irq);
    rd(IDX_CAPT, 34'h3, 34'h1, "period");
    rd(IDX_CNT, 34'h0, 34'h1, "cleared");
    pin_en <= 1'b0;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_CNT, 34'h0, 34'h0, "count reset");
    `CHK("irq reset", ~(ovf_irq | cap_irq), 1'b0, cap_irq)
    finish_test();
  end
endmodule : ppc_timer_tb_top
`default_nettype wire
